// File: common/opcfg_cfg.svh
// Register offsets, field positions, reset values and decode figures of the output-path bank
`ifndef OPCFG_CFG_SVH
`define OPCFG_CFG_SVH

// Register offsets on the control port
`define OPCFG_POS_CFG_ADDR      8'h65
`define OPCFG_NEG_CFG_ADDR      8'h66
`define OPCFG_ADDR_W            8
`define OPCFG_DATA_W            8

// Reset values
`define OPCFG_POS_CFG_RESET     8'h20
`define OPCFG_NEG_CFG_RESET     8'h20

// Writable bit masks (bit 1 of the negative-leg register is reserved)
`define OPCFG_POS_CFG_WMASK     8'hFF
`define OPCFG_NEG_CFG_WMASK     8'hFD

// Field positions; bits 7:2 are common to both registers, bits 1:0 differ between them
`define OPCFG_DRIVE_MSB         7
`define OPCFG_DRIVE_LSB         6
`define OPCFG_LEVEL_MSB         5
`define OPCFG_LEVEL_LSB         3
`define OPCFG_IMP_BIT           2
`define OPCFG_ARR_BIT           1
`define OPCFG_BW_BIT            0
`define OPCFG_RSVD_BIT          1
`define OPCFG_CMTOL_BIT         0

// Level gains in dB for each usable level code
`define OPCFG_GAIN_P12          8'h0C
`define OPCFG_GAIN_P6           8'h06
`define OPCFG_GAIN_0            8'h00
`define OPCFG_GAIN_M6           8'hFA
`define OPCFG_GAIN_M12          8'hF4

// Converter bandwidth in kHz
`define OPCFG_BW_AUDIO_KHZ      8'h18
`define OPCFG_BW_WIDE_KHZ       8'h60

`endif

// File: common/opcfg_pkg.sv
// Types shared by the output-path configuration bank
package opcfg_pkg;

	// Output leg drive load
	typedef enum logic [1:0] {
		OPCFG_DRV_LINE  = 2'h0,
		OPCFG_DRV_HP    = 2'h1,
		OPCFG_DRV_LOWZ  = 2'h2,
		OPCFG_DRV_FDRCV = 2'h3
	} opcfg_drive_e;

	// Output leg level codes
	typedef enum logic [2:0] {
		OPCFG_LVL_RSV0 = 3'h0,
		OPCFG_LVL_RSV1 = 3'h1,
		OPCFG_LVL_P12  = 3'h2,
		OPCFG_LVL_P6   = 3'h3,
		OPCFG_LVL_0    = 3'h4,
		OPCFG_LVL_M6   = 3'h5,
		OPCFG_LVL_M12  = 3'h6,
		OPCFG_LVL_RSV7 = 3'h7
	} opcfg_level_e;

	// Output source codes held in the source-select register
	typedef enum logic [2:0] {
		OPCFG_SRC_RSV0  = 3'h0,
		OPCFG_SRC_DAC   = 3'h1,
		OPCFG_SRC_BYP   = 3'h2,
		OPCFG_SRC_MIX   = 3'h3,
		OPCFG_SRC_IND_A = 3'h4,
		OPCFG_SRC_IND_B = 3'h5,
		OPCFG_SRC_RSV6  = 3'h6,
		OPCFG_SRC_RSV7  = 3'h7
	} opcfg_source_e;

	typedef logic [7:0] opcfg_byte_t;

endpackage

// File: common/opcfg_reg_if.sv
// Write path and stored value of one 8-bit configuration register
`timescale 1ns/1ps
interface opcfg_reg_if;
	logic                 we;
	opcfg_pkg::opcfg_byte_t wdata;
	opcfg_pkg::opcfg_byte_t q;

	// Bank side drives writes, register side returns its contents
	modport owner (input we, input wdata, output q);
	modport user  (output we, output wdata, input q);
endinterface

// File: verilog/opcfg_reg8.sv
// One 8-bit configuration register with reset value and writable mask
`timescale 1ns/1ps
module opcfg_reg8 #(
	parameter logic [7:0] RESET_VAL = 8'h00,
	parameter logic [7:0] WMASK     = 8'hFF
) (
	// Clock and reset
	input  wire logic  clk,
	input  wire logic  srst,
	// Register access
	opcfg_reg_if.owner rif
);

	logic [7:0] val_q;
	logic [7:0] val_d;

	// Writable bits take the new data, masked bits keep reset value
	assign val_d = rif.we ? ((rif.wdata & WMASK) | (RESET_VAL & ~WMASK)) : val_q;

	// Storage
	always_ff @(posedge clk) begin
		if (srst) begin
			val_q <= RESET_VAL;
		end else begin
			val_q <= val_d;
		end
	end

	assign rif.q = val_q;

endmodule

// File: verilog/opcfg_top.sv
// Output-path configuration register bank with field decode and level advisories
// Summary of operation
// RULE1: Each leg has a two-bit drive field, bits 7:6, reset 00, four load codes.
// RULE2: Each leg has a three-bit level field, bits 5:3, reset 100; 0,1,7 reserved.
// RULE3: Software uses level code 2 only with analog bypass source alone.
// RULE4: Software uses level codes 3 and 5 only with bypass or mix source.
// RULE5: Level code 6 needs bypass or mix source and negative impedance at 4.4 kohm.
// RULE6: First register bit 2 sets negative input bypass impedance; 0 low, 1 high.
// RULE7: Second register bit 2 sets positive input bypass impedance, same encoding.
// RULE8: First register bit 1 selects bypass input: differential or single-ended.
// RULE9: First register bit 0 selects converter bandwidth, 24 kHz or 96 kHz.
// RULE10: Second register bit 0 selects common-mode tolerance, narrow or rail-to-rail.
// RULE11: Second register bit 1 is reserved, read-only, returns zero.
// RULE12: Second register sits at address 0x66 and resets to 0x20.
// RULE13: External source field codes: 1 converter, 2 bypass, 3 mixed.
// RULE14: Any written value is stored and read back unchanged, no error raised. The code forces bit 1 of the second register to zero.
`timescale 1ns/1ps
`include "opcfg_cfg.svh"
module opcfg_top (
	// Clock and reset
	input  wire logic                        clk,
	input  wire logic                        srst,
	// Register port from the control interface
	input  wire logic                        reg_wr_en,
	input  wire logic                        reg_rd_en,
	input  wire logic [`OPCFG_ADDR_W-1:0]    reg_addr,
	input  wire logic [`OPCFG_DATA_W-1:0]    reg_wdata,
	output logic      [`OPCFG_DATA_W-1:0]    reg_rdata,
	output logic                             reg_rd_valid,
	// Source select from the neighbouring register
	input  wire logic [2:0]                  output_source_sel,
	// Raw register fields
	output logic      [1:0]                  pos_leg_drive_sel,
	output logic      [1:0]                  neg_leg_drive_sel,
	output logic      [2:0]                  pos_leg_level_sel,
	output logic      [2:0]                  neg_leg_level_sel,
	output logic                             neg_input_bypass_impedance,
	output logic                             pos_input_bypass_impedance,
	output logic                             bypass_input_arrangement,
	output logic                             converter_bandwidth_sel,
	output logic                             common_mode_tolerance_sel,
	// Decoded drive loads, one-hot: line, headphone, low-z, differential receiver
	output logic      [3:0]                  pos_leg_drive_onehot,
	output logic      [3:0]                  neg_leg_drive_onehot,
	// Decoded level gain in dB, two's complement
	output logic      [7:0]                  pos_leg_gain_db,
	output logic      [7:0]                  neg_leg_gain_db,
	// Level advisories
	output logic                             pos_leg_level_reserved,
	output logic                             neg_leg_level_reserved,
	output logic                             pos_leg_level_allowed,
	output logic                             neg_leg_level_allowed,
	// Decoded source mode
	output logic                             src_dac_only,
	output logic                             src_bypass_only,
	output logic                             src_mix,
	// Decoded analog controls
	output logic                             single_ended_bypass,
	output logic      [7:0]                  converter_bw_khz,
	output logic                             rail_to_rail_cm
);

	// Register interfaces
	// One interface per register keeps its strobe, data and stored word together
	opcfg_reg_if pos_if ();
	opcfg_reg_if neg_if ();

	// Address decode
	// Only the two mapped offsets match; writes elsewhere are ignored, reads elsewhere return zero
	logic hit_pos;
	logic hit_neg;
	logic hit_any;

	assign hit_pos = (reg_addr == `OPCFG_POS_CFG_ADDR);
	assign hit_neg = (reg_addr == `OPCFG_NEG_CFG_ADDR); // [RULE12]
	assign hit_any = hit_pos | hit_neg;

	// Write strobes; every value is accepted, with bit 1 at 0x66 masked to zero [RULE14]
	// Restricted codes are stored too; the advisory outputs flag them instead
	assign pos_if.we    = reg_wr_en & hit_pos;
	assign pos_if.wdata = reg_wdata;
	assign neg_if.we    = reg_wr_en & hit_neg;
	assign neg_if.wdata = reg_wdata;

	// First output-config register (positive-leg drive and level)
	opcfg_reg8 #(
		.RESET_VAL (`OPCFG_POS_CFG_RESET),
		.WMASK     (`OPCFG_POS_CFG_WMASK)
	) u_pos_cfg (
		.clk  (clk),
		.srst (srst),
		.rif  (pos_if.owner)
	);

	// Second output-config register, reset 0x20, bit 1 held at zero
	// The mask keeps the reserved bit at its reset value whatever is written
	opcfg_reg8 #(
		.RESET_VAL (`OPCFG_NEG_CFG_RESET), // [RULE12]
		.WMASK     (`OPCFG_NEG_CFG_WMASK)  // [RULE11]
	) u_neg_cfg (
		.clk  (clk),
		.srst (srst),
		.rif  (neg_if.owner)
	);

	// Field extraction
	// The impedance bits sit in the opposite leg's register, hence the cross-over
	logic [1:0] pos_drive_w;
	logic [1:0] neg_drive_w;
	logic [2:0] pos_level_w;
	logic [2:0] neg_level_w;
	logic       neg_imp_w;
	logic       pos_imp_w;
	logic       arr_w;
	logic       bw_w;
	logic       cmtol_w;

	assign pos_drive_w = pos_if.q[`OPCFG_DRIVE_MSB:`OPCFG_DRIVE_LSB]; // [RULE1]
	assign neg_drive_w = neg_if.q[`OPCFG_DRIVE_MSB:`OPCFG_DRIVE_LSB]; // [RULE1]
	assign pos_level_w = pos_if.q[`OPCFG_LEVEL_MSB:`OPCFG_LEVEL_LSB]; // [RULE2]
	assign neg_level_w = neg_if.q[`OPCFG_LEVEL_MSB:`OPCFG_LEVEL_LSB]; // [RULE2]
	assign neg_imp_w   = pos_if.q[`OPCFG_IMP_BIT];                    // [RULE6]
	assign pos_imp_w   = neg_if.q[`OPCFG_IMP_BIT];                    // [RULE7]
	assign arr_w       = pos_if.q[`OPCFG_ARR_BIT];                    // [RULE8]
	assign bw_w        = pos_if.q[`OPCFG_BW_BIT];                     // [RULE9]
	assign cmtol_w     = neg_if.q[`OPCFG_CMTOL_BIT];                  // [RULE10]

	// Source mode decode
	// Source code comes from logic on this clock, so it needs no synchroniser
	logic src_dac_w;
	logic src_byp_w;
	logic src_mix_w;
	logic src_byp_or_mix_w;

	assign src_dac_w        = (output_source_sel == opcfg_pkg::OPCFG_SRC_DAC); // [RULE13]
	assign src_byp_w        = (output_source_sel == opcfg_pkg::OPCFG_SRC_BYP); // [RULE13]
	assign src_mix_w        = (output_source_sel == opcfg_pkg::OPCFG_SRC_MIX); // [RULE13]
	assign src_byp_or_mix_w = src_byp_w | src_mix_w;

	// Drive one-hot decode
	// All four drive codes are legal loads, so the shift covers every case
	logic [3:0] pos_drive_oh_w;
	logic [3:0] neg_drive_oh_w;

	assign pos_drive_oh_w = 4'h1 << pos_drive_w; // [RULE1]
	assign neg_drive_oh_w = 4'h1 << neg_drive_w; // [RULE1]

	// Level to gain in dB; reserved codes report 0 dB
	function automatic logic [7:0] level_gain(input logic [2:0] lvl);
		logic [7:0] g;
		g = `OPCFG_GAIN_0;
		case (lvl)
			opcfg_pkg::OPCFG_LVL_P12: g = `OPCFG_GAIN_P12;
			opcfg_pkg::OPCFG_LVL_P6:  g = `OPCFG_GAIN_P6;
			opcfg_pkg::OPCFG_LVL_0:   g = `OPCFG_GAIN_0;
			opcfg_pkg::OPCFG_LVL_M6:  g = `OPCFG_GAIN_M6;
			opcfg_pkg::OPCFG_LVL_M12: g = `OPCFG_GAIN_M12;
			default:                  g = `OPCFG_GAIN_0;
		endcase
		return g;
	endfunction

	// Reserved level codes
	function automatic logic level_rsv(input logic [2:0] lvl);
		return (lvl == opcfg_pkg::OPCFG_LVL_RSV0) || (lvl == opcfg_pkg::OPCFG_LVL_RSV1) ||
			(lvl == opcfg_pkg::OPCFG_LVL_RSV7);
	endfunction

	// Whether a level code suits the present source and impedance
	// Code 6 checks the negative input's impedance for both legs alike
	function automatic logic level_ok(input logic [2:0] lvl, input logic byp,
		input logic byp_mix, input logic nimp);
		logic ok;
		ok = 1'b0;
		case (lvl)
			opcfg_pkg::OPCFG_LVL_P12: ok = byp;                 // [RULE3]
			opcfg_pkg::OPCFG_LVL_P6:  ok = byp_mix;             // [RULE4]
			opcfg_pkg::OPCFG_LVL_0:   ok = 1'b1;
			opcfg_pkg::OPCFG_LVL_M6:  ok = byp_mix;             // [RULE4]
			opcfg_pkg::OPCFG_LVL_M12: ok = byp_mix & ~nimp;     // [RULE5]
			default:                  ok = 1'b0;                // [RULE2]
		endcase
		return ok;
	endfunction

	logic [7:0] pos_gain_w;
	logic [7:0] neg_gain_w;
	logic       pos_rsv_w;
	logic       neg_rsv_w;
	logic       pos_ok_w;
	logic       neg_ok_w;

	// Level decode for both legs
	assign pos_gain_w = level_gain(pos_level_w);
	assign neg_gain_w = level_gain(neg_level_w);
	assign pos_rsv_w  = level_rsv(pos_level_w);  // [RULE2]
	assign neg_rsv_w  = level_rsv(neg_level_w);  // [RULE2]
	assign pos_ok_w   = level_ok(pos_level_w, src_byp_w, src_byp_or_mix_w, neg_imp_w);
	assign neg_ok_w   = level_ok(neg_level_w, src_byp_w, src_byp_or_mix_w, neg_imp_w);

	// Analog control decode
	// One bit picks between the only two bandwidths
	logic [7:0] bw_khz_w;

	assign bw_khz_w = bw_w ? `OPCFG_BW_WIDE_KHZ : `OPCFG_BW_AUDIO_KHZ; // [RULE9]

	// Read data mux; unmapped addresses read zero, reserved bit already zero
	// A read beside a write to the same address returns the old value
	logic [7:0] rdata_d;

	assign rdata_d = hit_pos ? pos_if.q : (hit_neg ? neg_if.q : 8'h00); // [RULE11] [RULE14]

	// Readback path, one cycle after the read strobe
	// Read data holds until the next read, so the host may take it late
	always_ff @(posedge clk) begin
		if (srst) begin
			reg_rdata    <= 8'h00;
			reg_rd_valid <= 1'b0;
		end else begin
			reg_rdata    <= reg_rd_en ? rdata_d : reg_rdata;
			reg_rd_valid <= reg_rd_en;
		end
	end

	// Field values after reset, cut from the reset words so the two cannot drift apart
	localparam logic [7:0] POS_RST = `OPCFG_POS_CFG_RESET;
	localparam logic [7:0] NEG_RST = `OPCFG_NEG_CFG_RESET;

	// Raw field outputs, reset to the register reset words
	// Fields and decodes both lag the stored words by one edge and change together
	always_ff @(posedge clk) begin
		if (srst) begin
			pos_leg_drive_sel          <= POS_RST[`OPCFG_DRIVE_MSB:`OPCFG_DRIVE_LSB];
			neg_leg_drive_sel          <= NEG_RST[`OPCFG_DRIVE_MSB:`OPCFG_DRIVE_LSB];
			pos_leg_level_sel          <= POS_RST[`OPCFG_LEVEL_MSB:`OPCFG_LEVEL_LSB];
			neg_leg_level_sel          <= NEG_RST[`OPCFG_LEVEL_MSB:`OPCFG_LEVEL_LSB];
			neg_input_bypass_impedance <= POS_RST[`OPCFG_IMP_BIT];
			pos_input_bypass_impedance <= NEG_RST[`OPCFG_IMP_BIT];
			bypass_input_arrangement   <= POS_RST[`OPCFG_ARR_BIT];
			converter_bandwidth_sel    <= POS_RST[`OPCFG_BW_BIT];
			common_mode_tolerance_sel  <= NEG_RST[`OPCFG_CMTOL_BIT];
		end else begin
			pos_leg_drive_sel          <= pos_drive_w; // [RULE1]
			neg_leg_drive_sel          <= neg_drive_w; // [RULE1]
			pos_leg_level_sel          <= pos_level_w; // [RULE2]
			neg_leg_level_sel          <= neg_level_w; // [RULE2]
			neg_input_bypass_impedance <= neg_imp_w;   // [RULE6]
			pos_input_bypass_impedance <= pos_imp_w;   // [RULE7]
			bypass_input_arrangement   <= arr_w;       // [RULE8]
			converter_bandwidth_sel    <= bw_w;        // [RULE9]
			common_mode_tolerance_sel  <= cmtol_w;     // [RULE10]
		end
	end

	// Decoded drive and gain outputs
	// Reset values match drive code 0 and the 0 dB level
	always_ff @(posedge clk) begin
		if (srst) begin
			pos_leg_drive_onehot <= 4'h1;
			neg_leg_drive_onehot <= 4'h1;
			pos_leg_gain_db      <= `OPCFG_GAIN_0;
			neg_leg_gain_db      <= `OPCFG_GAIN_0;
		end else begin
			pos_leg_drive_onehot <= pos_drive_oh_w;
			neg_leg_drive_onehot <= neg_drive_oh_w;
			pos_leg_gain_db      <= pos_gain_w;
			neg_leg_gain_db      <= neg_gain_w;
		end
	end

	// Level advisories; informative only, writes are never refused
	// A disallowed code still takes effect; avoiding it is up to software
	always_ff @(posedge clk) begin
		if (srst) begin
			pos_leg_level_reserved <= 1'b0;
			neg_leg_level_reserved <= 1'b0;
			pos_leg_level_allowed  <= 1'b1;
			neg_leg_level_allowed  <= 1'b1;
		end else begin
			pos_leg_level_reserved <= pos_rsv_w;
			neg_leg_level_reserved <= neg_rsv_w;
			pos_leg_level_allowed  <= pos_ok_w; // [RULE3] [RULE4] [RULE5]
			neg_leg_level_allowed  <= neg_ok_w; // [RULE3] [RULE4] [RULE5]
		end
	end

	// Source mode and analog control outputs
	// Source flags take the same edge as the advisories that depend on them
	always_ff @(posedge clk) begin
		if (srst) begin
			src_dac_only        <= 1'b0;
			src_bypass_only     <= 1'b0;
			src_mix             <= 1'b0;
			single_ended_bypass <= 1'b0;
			converter_bw_khz    <= `OPCFG_BW_AUDIO_KHZ;
			rail_to_rail_cm     <= 1'b0;
		end else begin
			src_dac_only        <= src_dac_w; // [RULE13]
			src_bypass_only     <= src_byp_w; // [RULE13]
			src_mix             <= src_mix_w; // [RULE13]
			single_ended_bypass <= arr_w;     // [RULE8]
			converter_bw_khz    <= bw_khz_w;  // [RULE9]
			rail_to_rail_cm     <= cmtol_w;   // [RULE10]
		end
	end

endmodule

// File: tb/opcfg_top_monitor.sv
// Assertion checker for the output-path configuration bank
`timescale 1ns/1ps
module opcfg_top_monitor (
	// Clock, reset and register port
	input wire logic       clk,
	input wire logic       srst,
	input wire logic       reg_wr_en,
	input wire logic       reg_rd_en,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic       reg_rd_valid,
	input wire logic [2:0] output_source_sel,
	// Fields and decodes
	input wire logic [1:0] pos_leg_drive_sel,
	input wire logic [2:0] pos_leg_level_sel,
	input wire logic       neg_input_bypass_impedance,
	input wire logic       converter_bandwidth_sel,
	input wire logic [7:0] converter_bw_khz,
	input wire logic       pos_leg_level_reserved,
	input wire logic       pos_leg_level_allowed,
	input wire logic       src_mix
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	logic [7:0] wd1_q;
	logic [7:0] wd2_q;
	logic [2:0] src_q;
	logic       src_ok;
	logic       exp_ok;

	// Delayed write data and source, lined up with the field outputs
	always_ff @(posedge clk) begin
		wd1_q <= reg_wdata;
		wd2_q <= wd1_q;
		src_q <= output_source_sel;
	end

	// Expected advisory for the current level code
	assign src_ok = (src_q == 3'h2) || (src_q == 3'h3);
	assign exp_ok = (pos_leg_level_sel == 3'h4) || (pos_leg_level_sel == 3'h2 && src_q == 3'h2)
		|| ((pos_leg_level_sel == 3'h3 || pos_leg_level_sel == 3'h5) && src_ok)
		|| (pos_leg_level_sel == 3'h6 && src_ok && !neg_input_bypass_impedance);

	sequence wr_pos;
		reg_wr_en && reg_addr == 8'h65;
	endsequence
	sequence rd_neg;
		reg_rd_en && reg_addr == 8'h66;
	endsequence

	rd_valid_on_a: assert property (reg_rd_en |=> reg_rd_valid)
		else $error("read not answered");
	rd_valid_off_a: assert property (!reg_rd_en |=> !reg_rd_valid)
		else $error("stray read valid");
	rsvd_read_zero_a: assert property (rd_neg |=> reg_rdata[1] == 1'b0)
		else $error("reserved bit reads one");
	reset_fields_a: assert property (disable iff (1'b0)
		srst |=> pos_leg_drive_sel == 2'h0
		&& pos_leg_level_sel == 3'h4 && converter_bw_khz == 8'h18)
		else $error("fields not at reset values");
	pos_write_fields_a: assert property (
		wr_pos |-> ##2
		{pos_leg_drive_sel, pos_leg_level_sel, neg_input_bypass_impedance,
		converter_bandwidth_sel} == {wd2_q[7:2], wd2_q[0]})
		else $error("write not reflected on fields");
	bw_decode_a: assert property (
		converter_bw_khz == (converter_bandwidth_sel ? 8'h60 : 8'h18))
		else $error("bandwidth decode wrong");
	level_rsvd_flag_a: assert property (pos_leg_level_reserved ==
		(pos_leg_level_sel inside {3'h0, 3'h1, 3'h7}))
		else $error("reserved level flag wrong");
	level_allowed_a: assert property (
		!$past(srst) |-> pos_leg_level_allowed == exp_ok)
		else $error("level advisory wrong");
	src_mix_decode_a: assert property (!$past(srst) |-> src_mix == (src_q == 3'h3))
		else $error("mix source decode wrong");
endmodule

bind opcfg_top opcfg_top_monitor opcfg_top_monitor_inst (.clk(clk), .srst(srst),
	.reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
	.output_source_sel(output_source_sel), .pos_leg_drive_sel(pos_leg_drive_sel),
	.pos_leg_level_sel(pos_leg_level_sel),
	.neg_input_bypass_impedance(neg_input_bypass_impedance),
	.converter_bandwidth_sel(converter_bandwidth_sel), .converter_bw_khz(converter_bw_khz),
	.pos_leg_level_reserved(pos_leg_level_reserved),
	.pos_leg_level_allowed(pos_leg_level_allowed), .src_mix(src_mix));

// File: tb/opcfg_top_tb.sv
// Self-checking testbench for the output-path configuration bank
`timescale 1ns/1ps
module opcfg_top_tb;
	logic       clk, srst, wr, rd, rv, nimp, pimp, arr, bw, cm, pres, nres;
	logic       pok, nok, sdac, sbyp, smix, se, r2r;
	logic [7:0] addr, wd, rdata, pg, ng, khz;
	logic [2:0] src, pl, nl;
	logic [1:0] pd, nd;
	logic [3:0] poh, noh;
	int         err_total, checks_done;

	opcfg_top opcfg_top_inst (.clk(clk), .srst(srst), .reg_wr_en(wr), .reg_rd_en(rd),
		.reg_addr(addr), .reg_wdata(wd), .reg_rdata(rdata), .reg_rd_valid(rv),
		.output_source_sel(src), .pos_leg_drive_sel(pd), .neg_leg_drive_sel(nd),
		.pos_leg_level_sel(pl), .neg_leg_level_sel(nl), .neg_input_bypass_impedance(nimp),
		.pos_input_bypass_impedance(pimp), .bypass_input_arrangement(arr),
		.converter_bandwidth_sel(bw), .common_mode_tolerance_sel(cm),
		.pos_leg_drive_onehot(poh), .neg_leg_drive_onehot(noh), .pos_leg_gain_db(pg),
		.neg_leg_gain_db(ng), .pos_leg_level_reserved(pres), .neg_leg_level_reserved(nres),
		.pos_leg_level_allowed(pok), .neg_leg_level_allowed(nok), .src_dac_only(sdac),
		.src_bypass_only(sbyp), .src_mix(smix), .single_ended_bypass(se),
		.converter_bw_khz(khz), .rail_to_rail_cm(r2r));

	// 50 MHz clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Expected gain in dB for a level code
	function automatic logic [7:0] gain(input logic [2:0] l);
		case (l)
			3'h2: gain = 8'h0C;
			3'h3: gain = 8'h06;
			3'h5: gain = 8'hFA;
			3'h6: gain = 8'hF4;
			default: gain = 8'h00;
		endcase
	endfunction

	// Expected advisory for level, source and impedance
	function automatic logic okx(input logic [2:0] l, input logic [2:0] s, input logic n);
		okx = (l == 3'h4) || (l == 3'h2 && s == 3'h2)
			|| ((l == 3'h3 || l == 3'h5) && (s == 3'h2 || s == 3'h3))
			|| (l == 3'h6 && (s == 3'h2 || s == 3'h3) && !n);
	endfunction

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Write, then wait until fields and decodes have settled
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		wr = 1'b1;
		addr = a;
		wd = d;
		@(negedge clk);
		wr = 1'b0;
		repeat (2) @(negedge clk);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk);
		rd = 1'b1;
		addr = a;
		@(negedge clk);
		rd = 1'b0;
		chk({7'h00, rv}, 8'h01);
		chk(rdata, exp);
	endtask

	task automatic t_reset();
		srst = 1'b1;
		repeat (4) @(negedge clk);
		srst = 1'b0;
		rd_chk(8'h65, 8'h20);
		rd_chk(8'h66, 8'h20);
		chk({pd, nd, poh}, 8'h01);
		chk({pl, nl, 2'h0}, 8'h90);
		chk({nimp, pimp, arr, bw, cm, 3'h0}, 8'h00);
		chk(khz, 8'h18);
		$display("test reset done");
	endtask

	task automatic t_drive();
		for (int d = 0; d < 4; d++) begin
			wr_reg(8'h65, {d[1:0], 6'h20});
			wr_reg(8'h66, {~d[1:0], 6'h20});
			chk({pd, nd, poh}, {d[1:0], ~d[1:0], 4'h1 << d});
			chk({4'h0, noh}, {4'h0, 4'h1 << (3 - d)});
		end
		$display("test drive done");
	endtask

	task automatic t_level();
		logic r;
		for (int s = 1; s < 4; s++) begin
			for (int n = 0; n < 2; n++) begin
				for (int l = 0; l < 8; l++) begin
					r = (l == 0) || (l == 1) || (l == 7);
					src = s[2:0];
					wr_reg(8'h65, {2'h0, l[2:0], n[0], 2'h0});
					wr_reg(8'h66, {2'h0, l[2:0], 3'h0});
					rd_chk(8'h65, {2'h0, l[2:0], n[0], 2'h0});
					chk({pok, nok, pres, nres, sdac, sbyp, smix, 1'b0},
						{{2{okx(l[2:0], s[2:0], n[0])}}, r, r,
						s == 1, s == 2, s == 3, 1'b0});
					chk(pg, gain(l[2:0]));
					chk(ng, gain(l[2:0]));
				end
			end
		end
		$display("test level done");
	endtask

	task automatic t_bits();
		wr_reg(8'h65, 8'h27);
		wr_reg(8'h66, 8'hFF);
		rd_chk(8'h66, 8'hFD);
		chk({nimp, arr, bw, se, pimp, cm, r2r, 1'b0}, 8'hFE);
		chk(khz, 8'h60);
		wr_reg(8'h66, 8'h20);
		chk({pimp, cm, r2r, 5'h0}, 8'h00);
		wr_reg(8'h67, 8'h55);
		rd_chk(8'h67, 8'h00);
		rd_chk(8'h65, 8'h27);
		$display("test bits done");
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Watchdog against a hang
	initial begin
		repeat (5000) @(posedge clk);
		err_total++;
		end_sim();
	end

	// Main sequence, ending with a reset in mid-run
	initial begin
		srst = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h00;
		wd = 8'h00;
		src = 3'h1;
		err_total = 0;
		checks_done = 0;
		t_reset();
		t_drive();
		t_level();
		t_bits();
		t_reset();
		end_sim();
	end
endmodule
